// *** verilog/sahp_host_port.sv ***
// Purpose: Control and host port of a 12-bit simultaneous-sampling ADC.
// Assumes: All pins synchronous to clk_i; rst_i stands in for power-up.
// Notes:   Analog core converts conv_channel_o and offers conv_data_i.
`timescale 1ns/1ps
module sahp_host_port #(
	parameter int CHANNELS = 8,
	parameter int INT_DIV  = sahp_pkg::INT_CONV_DIV
) (
	input  wire logic                          clk_i,                       // System clock
	input  wire logic                          rst_i,                       // Power-up reset
	input  wire logic                          sample_convert_strobe_i,     // Track low, hold high
	input  wire logic                          clock_source_select_i,       // High: internal
	input  wire logic                          ext_conv_clk_i,              // External clock
	input  wire logic                          power_down_i,                // Shutdown, high
	input  wire logic                          idle_channel_power_down_n_i, // Low: idle off
	input  wire sahp_pkg::sahp_bus_s           bus_i,                       // Strobes, low
	input  wire logic [sahp_pkg::LOW_W-1:0]    low_data_lines_i,            // Write data
	output logic [sahp_pkg::LOW_W-1:0]         low_data_lines_o,            // Read data low
	output logic                               low_data_lines_oe_o,         // Drive low lines
	output logic [sahp_pkg::HIGH_W-1:0]        high_data_lines_o,           // Read data high
	output logic                               high_data_lines_oe_o,        // Drive high lines
	output logic                               result_ready_n_o,            // Result pulse
	output logic                               last_result_ready_n_o,       // Last result
	output logic [sahp_pkg::MAX_CH-1:0]        track_hold_o,                // 1: hold
	output logic [sahp_pkg::MAX_CH-1:0]        channel_power_o,             // 1: powered
	output logic [2:0]                         conv_channel_o,              // Channel in work
	input  wire logic [sahp_pkg::RESULT_W-1:0] conv_data_i                  // Core result
);
	import sahp_pkg::*;

	generate
		if (!(CHANNELS == 8 || CHANNELS == 4 || CHANNELS == 2)) begin : g_bad_ch
			$error("sahp_host_port: CHANNELS must be 8, 4 or 2");
		end
	endgenerate

	localparam logic [MAX_CH-1:0] CH_MASK = MAX_CH'((1 << CHANNELS) - 1);

	// Lowest set bit: {found, index}
	function automatic logic [3:0] lowest(input logic [MAX_CH-1:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = MAX_CH - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = {1'b1, 3'(i)};
			end
		end
		return r;
	endfunction : lowest

	////////////////////////////////////////////////////////////////////////
	// Edge detection on the host pins
	logic strobe_q;
	logic pd_q;
	logic wr_act_q;
	logic rd_act_q;
	logic strobe_rise;
	logic strobe_fall;
	logic pd_fall;
	logic start;
	logic wr_end;
	logic rd_end;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strobe_q <= 1'b0;
			pd_q     <= 1'b0;
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
		end else begin
			strobe_q <= sample_convert_strobe_i;
			pd_q     <= power_down_i;
			wr_act_q <= ~bus_i.cs_n & ~bus_i.wr_n;
			rd_act_q <= ~bus_i.cs_n & ~bus_i.rd_n;
		end
	end

	// Leaving power-down starts a conversion as a strobe rise does
	assign strobe_rise = sample_convert_strobe_i & ~strobe_q;
	assign strobe_fall = ~sample_convert_strobe_i & strobe_q;
	assign pd_fall     = pd_q & ~power_down_i;
	assign start       = (strobe_rise & ~power_down_i) | pd_fall;
	assign wr_end      = wr_act_q & bus_i.wr_n;
	assign rd_end      = rd_act_q & bus_i.rd_n;

	////////////////////////////////////////////////////////////////////////
	// Channel-enable register, write-only, untouched by power-down
	logic [MAX_CH-1:0] cfg;
	logic [MAX_CH-1:0] next_cfg;
	logic [MAX_CH-1:0] wr_data;
	logic [MAX_CH-1:0] next_wr_data;

	always_comb begin
		next_cfg     = cfg;
		next_wr_data = wr_data;
		if (~bus_i.cs_n & ~bus_i.wr_n) begin
			next_wr_data = low_data_lines_i;
		end
		if (wr_end) begin
			next_cfg = wr_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg     <= CFG_RESET;
			wr_data <= CFG_RESET;
		end else begin
			cfg     <= next_cfg;
			wr_data <= next_wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer and result store
	sahp_state_e         state;
	sahp_state_e         next_state;
	logic [MAX_CH-1:0]   active;
	logic [MAX_CH-1:0]   next_active;
	logic [MAX_CH-1:0]   remain;
	logic [MAX_CH-1:0]   next_remain;
	logic [3:0]          cnt;
	logic [3:0]          next_cnt;
	logic [2:0]          cur_ch;
	logic [2:0]          next_cur_ch;
	logic [3:0]          nstored;
	logic [3:0]          next_nstored;
	logic                eoc_n;
	logic                next_eoc_n;
	logic                last_result_ready_n_n;
	logic                next_last_result_ready_n_n;
	logic [RESULT_W-1:0] res_mem [MAX_CH];
	logic [RESULT_W-1:0] next_res_mem [MAX_CH];
	logic                tick;
	logic [3:0]          low_a;
	logic [3:0]          low_r;
	logic [MAX_CH-1:0]   left;

	sahp_conv_tick #(
		.DIV                   (INT_DIV)
	) u_tick (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.clock_source_select_i (clock_source_select_i),
		.ext_conv_clk_i        (ext_conv_clk_i),
		.run_i                 (state != ST_TRACK),
		.tick_o                (tick)
	);

	// Abort and power-down win over conversion progress
	always_comb begin
		next_state   = state;
		next_active  = active;
		next_remain  = remain;
		next_cnt     = cnt;
		next_cur_ch  = cur_ch;
		next_nstored = nstored;
		next_eoc_n   = eoc_n;
		next_last_result_ready_n_n  = last_result_ready_n_n;
		next_res_mem = res_mem;
		low_a        = lowest(active);
		left         = remain & ~(MAX_CH'(1) << cur_ch);
		low_r        = lowest(left);
		if (strobe_fall) begin
			next_active = cfg & CH_MASK;
			next_state  = ST_TRACK;
			next_eoc_n  = 1'b1;
			next_last_result_ready_n_n = 1'b1;
		end else if (power_down_i) begin
			next_state  = ST_TRACK;
			next_eoc_n  = 1'b1;
			next_last_result_ready_n_n = 1'b1;
		end else if (start) begin
			next_eoc_n   = 1'b1;
			next_last_result_ready_n_n  = 1'b1;
			next_nstored = 4'h0;
			next_remain  = active;
			next_cur_ch  = low_a[2:0];
			next_cnt     = FIRST_RESULT_EDGE;
			next_state   = low_a[3] ? ST_CONV : ST_TRACK;
		end else if (state == ST_CONV && tick) begin
			next_eoc_n = 1'b1;
			if (cnt == LAST_EDGE) begin
				next_res_mem[nstored[2:0]] = conv_data_i;
				next_nstored = nstored + 4'h1;
				next_eoc_n   = 1'b0;
				next_remain  = left;
				if (low_r[3]) begin
					next_cur_ch = low_r[2:0];
					next_cnt    = NEXT_RESULT_EDGES;
				end else begin
					next_last_result_ready_n_n = 1'b0;
					next_state  = ST_DONE;
				end
			end else begin
				next_cnt = cnt - 4'h1;
			end
		end else if (state == ST_DONE && tick) begin
			next_eoc_n = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state   <= ST_TRACK;
			active  <= CFG_RESET & CH_MASK;
			remain  <= '0;
			cnt     <= 4'h0;
			cur_ch  <= 3'h0;
			nstored <= 4'h0;
			eoc_n   <= 1'b1;
			last_result_ready_n_n  <= 1'b1;
			for (int i = 0; i < MAX_CH; i++) begin
				res_mem[i] <= '0;
			end
		end else begin
			state   <= next_state;
			active  <= next_active;
			remain  <= next_remain;
			cnt     <= next_cnt;
			cur_ch  <= next_cur_ch;
			nstored <= next_nstored;
			eoc_n   <= next_eoc_n;
			last_result_ready_n_n  <= next_last_result_ready_n_n;
			res_mem <= next_res_mem;
		end
	end

	// Every active channel holds on the same strobe level
	generate
		for (genvar k = 0; k < MAX_CH; k++) begin : g_ch
			assign track_hold_o[k]    = sample_convert_strobe_i & active[k];
			assign channel_power_o[k] = ~power_down_i & CH_MASK[k]
			                          & (idle_channel_power_down_n_i | cfg[k]);
		end
	endgenerate

	assign result_ready_n_o      = eoc_n;
	assign last_result_ready_n_o = last_result_ready_n_n;
	assign conv_channel_o        = cur_ch;

	////////////////////////////////////////////////////////////////////////
	// Read port: results only, the enable register is never visible
	logic [2:0]          rd_ptr;
	logic [2:0]          next_rd_ptr;
	logic [RESULT_W-1:0] rd_data;
	logic [RESULT_W-1:0] next_rd_data;

	always_comb begin
		next_rd_ptr  = rd_ptr;
		next_rd_data = res_mem[rd_ptr];
		if (start) begin
			next_rd_ptr = 3'h0;
		end else if (rd_end) begin
			if ({1'b0, rd_ptr} + 4'h1 >= nstored) begin
				next_rd_ptr = 3'h0;
			end else begin
				next_rd_ptr = rd_ptr + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_ptr  <= 3'h0;
			rd_data <= '0;
		end else begin
			rd_ptr  <= next_rd_ptr;
			rd_data <= next_rd_data;
		end
	end

	// Drive only while both select and read are low, whatever power-down says
	assign low_data_lines_oe_o  = ~bus_i.cs_n & ~bus_i.rd_n;
	assign high_data_lines_oe_o = ~bus_i.cs_n & ~bus_i.rd_n;
	assign low_data_lines_o     = rd_data[LOW_W-1:0];
	assign high_data_lines_o    = rd_data[RESULT_W-1:LOW_W];

	////////////////////////////////////////////////////////////////////////
	// Checks: edge counter since the start, used only by the assertions
	localparam int FIRST_I = 13;
	localparam int STEP_I  = 3;
	logic [5:0] edge_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i || start) begin
			edge_cnt <= 6'h0;
		end else if (state == ST_CONV && tick && edge_cnt != 6'h3f) begin
			edge_cnt <= edge_cnt + 6'h1;
		end
	end

	property p_hold_level;
		@(posedge clk_i) disable iff (rst_i)
		!sample_convert_strobe_i |-> (track_hold_o == '0);
	endproperty
	a_hold_level: assert property (p_hold_level) else $error("hold while tracking");

	property p_hold_all;
		@(posedge clk_i) disable iff (rst_i)
		sample_convert_strobe_i |-> (track_hold_o == active);
	endproperty
	a_hold_all: assert property (p_hold_all) else $error("channels not held together");

	property p_first_edge;
		@(posedge clk_i) disable iff (rst_i)
		($fell(result_ready_n_o) && nstored == 4'h1) |-> (int'(edge_cnt) == FIRST_I);
	endproperty
	a_first_edge: assert property (p_first_edge) else $error("first result edge wrong");

	property p_last_time;
		@(posedge clk_i) disable iff (rst_i)
		$fell(last_result_ready_n_o) |->
			(int'(edge_cnt) == FIRST_I + STEP_I * (int'(nstored) - 1));
	endproperty
	a_last_time: assert property (p_last_time) else $error("last result time wrong");

	property p_pulse_end;
		@(posedge clk_i) disable iff (rst_i)
		(!result_ready_n_o && (tick || strobe_fall)) |=> result_ready_n_o;
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("result pulse too long");

	property p_last_hold;
		@(posedge clk_i) disable iff (rst_i)
		(!last_result_ready_n_o && sample_convert_strobe_i && strobe_q && !power_down_i)
			|=> !last_result_ready_n_o;
	endproperty
	a_last_hold: assert property (p_last_hold) else $error("last flag dropped early");

	property p_defer;
		@(posedge clk_i) disable iff (rst_i)
		!strobe_fall |=> $stable(active);
	endproperty
	a_defer: assert property (p_defer) else $error("enables applied early");

	property p_write;
		@(posedge clk_i) disable iff (rst_i)
		(!bus_i.cs_n && !bus_i.wr_n) ##1 bus_i.wr_n |=> (cfg == $past(low_data_lines_i, 2));
	endproperty
	a_write: assert property (p_write) else $error("write not captured");

	property p_release;
		@(posedge clk_i) disable iff (rst_i)
		(bus_i.cs_n || bus_i.rd_n) |-> !(low_data_lines_oe_o || high_data_lines_oe_o);
	endproperty
	a_release: assert property (p_release) else $error("bus driven while idle");

	property p_wrap;
		@(posedge clk_i) disable iff (rst_i)
		(rd_end && !start && {1'b0, rd_ptr} + 4'h1 >= nstored) |=> (rd_ptr == 3'h0);
	endproperty
	a_wrap: assert property (p_wrap) else $error("read pointer did not wrap");

	property p_reset_cfg;
		@(posedge clk_i) rst_i |=> (cfg == CFG_RESET);
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("enables not all on");

	c_conv_done: cover property (@(posedge clk_i) disable iff (rst_i)
		$fell(last_result_ready_n_o));
	c_abort: cover property (@(posedge clk_i) disable iff (rst_i)
		(state == ST_CONV) && strobe_fall);
	c_read_wrap: cover property (@(posedge clk_i) disable iff (rst_i)
		rd_end && rd_ptr != 3'h0 ##1 rd_ptr == 3'h0);
	c_write_conv: cover property (@(posedge clk_i) disable iff (rst_i)
		wr_end && state == ST_CONV);

endmodule : sahp_host_port

// *** include/sahp_pkg.sv ***
// Purpose: Shared constants and types of the simultaneous ADC host port.
// Assumes: System clock of 10 MHz; all pins synchronous to it.
// Notes:   Conversion timing is counted in conversion-clock rising edges.
package sahp_pkg;

	// System and conversion clock rates
	localparam int SYS_CLK_HZ      = 10_000_000;
	localparam int INT_CONV_CLK_HZ = 15_000_000;
	// Internal conversion clock cannot exceed the system clock, so it saturates at one tick a cycle
	localparam int INT_CONV_DIV    = (SYS_CLK_HZ / INT_CONV_CLK_HZ < 1) ? 1
	                               : SYS_CLK_HZ / INT_CONV_CLK_HZ;

	// Widths
	localparam int MAX_CH   = 8;
	localparam int RESULT_W = 12;
	localparam int LOW_W    = 8;
	localparam int HIGH_W   = 4;

	// Channel-enable reset value: all channels on
	localparam logic [7:0] CFG_RESET = 8'hff;

	// Result timing in conversion-clock rising edges
	localparam logic [3:0] FIRST_RESULT_EDGE = 4'hd;
	localparam logic [3:0] NEXT_RESULT_EDGES = 4'h3;
	localparam logic [3:0] LAST_EDGE         = 4'h1;

	// Host bus strobes, all active low
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
	} sahp_bus_s;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_TRACK,
		ST_CONV,
		ST_DONE
	} sahp_state_e;

endpackage : sahp_pkg

// *** verilog/sahp_conv_tick.sv ***
// Purpose: Conversion clock tick source, internal divider or external clock edges.
// Assumes: External clock pin is synchronous to clk_i.
// Notes:   Ticks only while run_i is high; the divider restarts with each run.
`timescale 1ns/1ps
module sahp_conv_tick #(
	parameter int DIV = sahp_pkg::INT_CONV_DIV
) (
	input  wire logic clk_i,                 // System clock
	input  wire logic rst_i,                 // Synchronous reset, high
	input  wire logic clock_source_select_i, // High: internal clock mode
	input  wire logic ext_conv_clk_i,        // External conversion clock
	input  wire logic run_i,                 // Conversion in progress
	output logic      tick_o                 // One pulse per conversion clock edge
);
	import sahp_pkg::*;

	localparam int CW = (DIV < 2) ? 1 : $clog2(DIV);

	generate
		if (DIV < 1) begin : g_bad_div
			$error("sahp_conv_tick: DIV must be at least 1");
		end
	endgenerate

	logic [CW-1:0] div_cnt;
	logic [CW-1:0] next_div_cnt;
	logic          ext_q;
	logic          next_ext_q;
	logic          div_hit;

	////////////////////////////////////////////////////////////////////////
	// Divider restarts at each run so the first tick is a full period late
	always_comb begin
		div_hit      = (div_cnt == CW'(DIV - 1));
		next_ext_q   = ext_conv_clk_i;
		next_div_cnt = div_cnt;
		if (!run_i || div_hit) begin
			next_div_cnt = '0;
		end else begin
			next_div_cnt = div_cnt + CW'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_cnt <= '0;
			ext_q   <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			ext_q   <= next_ext_q;
		end
	end

	// External mode counts only rising edges of the supplied clock
	assign tick_o = run_i & (clock_source_select_i ? div_hit
	                                               : (ext_conv_clk_i & ~ext_q));

endmodule : sahp_conv_tick

// *** dv/sahp_host_model.sv ***
// Purpose: Host side of the parallel bus, plus the sampling strobe and shutdown pin.
// Assumes: Every request is driven 1 ns after a rising clk_i edge.
// Notes:   Released data lines show the inverse of the last value, so stale data never matches.
`timescale 1ns/1ps
module sahp_host_model (
	input  wire logic                   clk_i,    // System clock
	output sahp_pkg::sahp_bus_s         bus_o,    // Select, read, write, active low
	output logic [sahp_pkg::LOW_W-1:0]  data_o,   // Write data toward the device
	output logic                        strobe_o, // Low: track, high: hold
	output logic                        pd_o      // High: shutdown
);
	import sahp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Idle levels at time zero
	initial begin
		bus_o    = 3'b111;
		data_o   = 8'h5a;
		strobe_o = 1'b0;
		pd_o     = 1'b0;
	end

	// Raw strobe levels, one change per clock edge
	task automatic drive(input logic cs_n, input logic rd_n, input logic wr_n);
		@(posedge clk_i);
		#1;
		bus_o = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n};
	endtask : drive

	// Enable write: all eight bits driven, even unused ones, then wr_n rises
	task automatic wr_cfg(input logic [7:0] d, input logic cs_n);
		drive(cs_n, 1'b1, 1'b0);
		data_o = d;
		drive(cs_n, 1'b1, 1'b1);
		drive(1'b1, 1'b1, 1'b1);
		data_o = ~d;
	endtask : wr_cfg

	// Strobe low is held at least three cycles by callers, well inside 100 ns .. 1 ms
	task automatic set_strobe(input logic v);
		@(posedge clk_i);
		#1;
		strobe_o = v;
	endtask : set_strobe

	task automatic set_pd(input logic v);
		@(posedge clk_i);
		#1;
		pd_o = v;
	endtask : set_pd
endmodule : sahp_host_model

// *** dv/tb.sv ***
// Purpose: Self-checking bench of the simultaneous ADC host port.
// Assumes: Internal divider of 1; external clock rises every fourth system cycle.
// Notes:   Core data is the channel number with a fixed marker, so order is visible.
`timescale 1ns/1ps
module tb;
	import sahp_pkg::*;

	logic             clk_i;
	logic             rst_i;
	logic             sel;
	logic             ext_clk;
	logic [1:0]       ext_div;
	sahp_bus_s        bus;
	logic [7:0]       hdata;
	logic [7:0]       low_o;
	logic [7:0]       low_in;
	logic             low_oe;
	logic             high_oe;
	logic [3:0]       high_o;
	logic             rdy_n;
	logic             last_n;
	logic [7:0]       th;
	logic [2:0]       ch;
	logic [7:0]       pwr;
	logic             idle_n;
	logic [11:0]      core;
	logic             strobe;
	logic             pd;
	int               fail_count;
	int               n_compared;
	int               cyc = 0;

	////////////////////////////////////////////////////////////////////////////
	// Clock, external conversion clock held low in internal mode
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_div <= 2'h0;
			ext_clk <= 1'b0;
		end else begin
			ext_div <= ext_div + 2'h1;
			ext_clk <= sel ? 1'b0 : ext_div[1];
		end
	end

	// Wire level of the two-way lines and a core that returns its channel
	assign low_in = low_oe ? low_o : hdata;
	assign core   = {4'ha, 5'h00, ch};

	sahp_host_model u_sahp_host_model (
		.clk_i    (clk_i),
		.bus_o    (bus),
		.data_o   (hdata),
		.strobe_o (strobe),
		.pd_o     (pd)
	);

	sahp_host_port u_sahp_host_port (
		.clk_i                       (clk_i),
		.rst_i                       (rst_i),
		.sample_convert_strobe_i     (strobe),
		.clock_source_select_i       (sel),
		.ext_conv_clk_i              (ext_clk),
		.power_down_i                (pd),
		.idle_channel_power_down_n_i (idle_n),
		.bus_i                       (bus),
		.low_data_lines_i            (low_in),
		.low_data_lines_o            (low_o),
		.low_data_lines_oe_o         (low_oe),
		.high_data_lines_o           (high_o),
		.high_data_lines_oe_o        (high_oe),
		.result_ready_n_o            (rdy_n),
		.last_result_ready_n_o       (last_n),
		.track_hold_o                (th),
		.channel_power_o             (pwr),
		.conv_channel_o              (ch),
		.conv_data_i                 (core)
	);

	////////////////////////////////////////////////////////////////////////////
	// Compare tasks and the single closing point
	task automatic chkv(input string what, input logic [11:0] exp, input logic [11:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chkv

	task automatic chki(input string what, input int exp, input int got);
		n_compared++;
		if (got != exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chki

	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	// Hang guard: the whole sequence needs well under 3000 cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One read cycle; pointer moves once rd_n is seen high again
	task automatic read_word(input logic [11:0] exp);
		u_sahp_host_model.drive(1'b0, 1'b0, 1'b1);
		#1;
		chkv("read data", exp, {high_o, low_o});
		chkv("drive both halves", 12'h003, {10'h000, low_oe, high_oe});
		u_sahp_host_model.drive(1'b1, 1'b1, 1'b1);
		#1;
		chkv("released", 12'h000, {10'h000, low_oe, high_oe});
		repeat (2) @(posedge clk_i);
	endtask : read_word

	// Reads every enabled channel in ascending order, then one wrapped read
	task automatic read_all(input logic [7:0] mask);
		logic [2:0] q[$];
		for (int k = 0; k < 8; k++)
			if (mask[k])
				q.push_back(3'(k));
		foreach (q[i])
			read_word({4'ha, 5'h00, q[i]});
		read_word({4'ha, 5'h00, q[0]});
		chkv("last flag held", 12'h000, 12'(last_n));
		// The last pulse must end on a later conversion clock edge, not linger
		chkv("result pulse ended", 12'h001, 12'(rdy_n));
	endtask : read_all

	// Track, sample, then time every result pulse; first is 0 in external mode
	task automatic conv(input int n, input int gap, input int first, input logic [7:0] mask);
		int   pulses;
		int   lows;
		int   t;
		int   last_t;
		int   first_t;
		logic prev;
		pulses = 0;
		lows = 0;
		last_t = 0;
		first_t = 0;
		prev = 1'b1;
		u_sahp_host_model.set_strobe(1'b0);
		repeat (2) @(posedge clk_i);
		#1;
		chkv("tracking", 12'h000, 12'(th));
		u_sahp_host_model.set_strobe(1'b1);
		for (t = 1; t < 600 && last_n !== 1'b0; t++) begin
			@(posedge clk_i);
			#1;
			if (t == 1)
				chkv("holding", 12'(mask), 12'(th));
			if (rdy_n === 1'b0)
				lows++;
			if (prev === 1'b1 && rdy_n === 1'b0) begin
				pulses++;
				if (pulses == 1)
					first_t = t;
				else
					chki("result spacing", gap, t - last_t);
				last_t = t;
			end
			prev = rdy_n;
		end
		chki("result count", n, pulses);
		chki("last with final result", last_t, t - 1);
		if (first != 0) begin
			chki("first result", first, first_t);
			chki("pulse width", n, lows);
		end
	endtask : conv

	// Strobe fall ends the sequence and clears the last-result flag
	task automatic drop();
		u_sahp_host_model.set_strobe(1'b0);
		repeat (2) @(posedge clk_i);
		#1;
		chkv("last flag cleared", 12'h001, 12'(last_n));
	endtask : drop

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_i = 1'b1;
		sel = 1'b1;
		idle_n = 1'b1;
		fail_count = 0;
		n_compared = 0;
		repeat (3) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		// Power-up mask converts all eight; first result after 13 ticks from the start edge
		conv(8, 3, 14, 8'hff);
		read_all(8'hff);
		// Sparse mask written while the strobe is high; the strobe fall applies it
		u_sahp_host_model.wr_cfg(8'h88, 1'b0);
		drop();
		// Released lines when only one of select and read is low
		u_sahp_host_model.drive(1'b1, 1'b0, 1'b1);
		#1;
		chkv("select high", 12'h000, {10'h000, low_oe, high_oe});
		u_sahp_host_model.drive(1'b0, 1'b1, 1'b1);
		#1;
		chkv("read high", 12'h000, {10'h000, low_oe, high_oe});
		u_sahp_host_model.drive(1'b1, 1'b1, 1'b1);
		conv(2, 3, 14, 8'h88);
		read_all(8'h88);
		// Write mid-sequence: accepted, but selection waits for a strobe fall
		u_sahp_host_model.wr_cfg(8'h01, 1'b0);
		#1;
		chkv("mask unchanged", 12'h088, 12'(th));
		drop();
		conv(1, 3, 14, 8'h01);
		read_all(8'h01);
		// Shutdown clears flags, keeps the register and still takes writes
		u_sahp_host_model.set_pd(1'b1);
		repeat (2) @(posedge clk_i);
		#1;
		chkv("flags in shutdown", 12'h003, {10'h000, rdy_n, last_n});
		chkv("power in shutdown", 12'h000, 12'(pwr));
		u_sahp_host_model.wr_cfg(8'h06, 1'b0);
		u_sahp_host_model.set_pd(1'b0);
		repeat (40) @(posedge clk_i);
		drop();
		// Idle channels follow the register; then external clock mode
		idle_n = 1'b0;
		sel = 1'b0;
		#1;
		chkv("idle channels off", 12'h006, 12'(pwr));
		// A write with select high must be ignored
		u_sahp_host_model.wr_cfg(8'h00, 1'b1);
		conv(2, 12, 0, 8'h06);
		read_all(8'h06);
		drop();
		end_sim();
	end
endmodule : tb
